// >>> core/plfc_core.sv
// serial load port, function/init latches, power-down and fastlock control
`timescale 1ns/1ns
module plfc_core
   import plfc_pkg::*;
(
   input  wire logic        i_clk,                 // 50 MHz system clock
   input  wire logic        i_rst,                 // synchronous reset, active high
   input  wire logic        i_ce,                  // clock enable, freezes state when low
   input  wire logic        i_sclk,                // serial clock, sampled
   input  wire logic        i_sdata,               // serial data, msb first
   input  wire logic        i_load_strobe,         // load strobe, rising edge latches
   input  wire logic        i_enable_pin,          // enable pin, low powers down
   input  wire logic        i_pump_event,          // one-cycle charge pump event
   input  wire logic        i_pd_tick,             // one-cycle detector cycle tick
   output logic             o_powerdown,           // device powered down
   output logic             o_counter_load,        // R, N and timeout counters at load
   output logic             o_pump_highz,          // pump output in high impedance
   output logic             o_lock_detect_reset,   // digital lock detect held in reset
   output logic             o_internal_reset,      // one-cycle internal reset pulse
   output logic [2:0]       o_pump_current_code,   // active pump current code
   output logic [1:0]       o_prescaler_select,    // prescaler select field
   output logic [2:0]       o_monitor_mux_select,  // monitor output select
   output logic             o_detector_polarity,   // phase detector polarity
   output logic [23:0]      o_r_word,              // R counter latch
   output logic [23:0]      o_ab_word              // AB counter latch
);

   logic [23:0]  shreg;
   logic         sclk_q;
   logic         load_q;
   plfc_func_t   func;
   logic         ab_first;
   plfc_pstate_t pstate;
   plfc_pstate_t next_pstate;
   logic [6:0]   tmr;
   logic         sclk_rise;
   logic         load_rise;
   logic [1:0]   sel;
   logic         fast_on;
   logic         mode2_run;
   logic [6:0]   tmr_limit;
   logic         tmr_expire;
   logic         next_pulse;
   logic         next_pd;
   logic         next_hold;

   // edge detection on sampled serial pins
   assign sclk_rise = i_sclk & ~sclk_q;
   assign load_rise = i_load_strobe & ~load_q;
   assign sel       = shreg[1:0];                                          // R23

   // serial pins are synchronous, so only a previous sample is kept
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         sclk_q <= 1'b0;
         load_q <= 1'b0;
      end else if (i_ce) begin
         sclk_q <= i_sclk;
         load_q <= i_load_strobe;
      end
   end

   // input shift register stays live in power-down
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         shreg <= WORD_RESET;
      end else if (i_ce && sclk_rise) begin
         shreg <= {shreg[22:0], i_sdata};                                  // R22 R7
      end
   end

   // function latch, written by both function and init words
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         func <= plfc_func_t'(WORD_RESET);
      end else if (i_ce && load_rise && sel[1]) begin
         func <= plfc_func_t'(shreg);                                      // R1 R16
      end
   end

   // R counter latch
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_r_word <= WORD_RESET;
      end else if (i_ce && load_rise && sel == SEL_R) begin
         o_r_word <= shreg;                                                // R23
      end
   end

   // timeout compare; a new AB word restarts the count from zero
   assign tmr_limit  = 7'({3'h0, func.fastlock_timeout_field} + 7'h01)
                       * TIMEOUT_STEP_TICKS;
   assign mode2_run  = func.fastlock_enable_bit & func.fastlock_mode_bit
                       & o_ab_word[POS_FAST_REQ] & ~o_counter_load;        // R12
   assign tmr_expire = mode2_run & i_pd_tick & (tmr == tmr_limit - 7'h01);

   // AB latch; a host write beats the timer clearing the request bit
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_ab_word <= WORD_RESET;
      end else if (i_ce) begin
         if (load_rise && sel == SEL_AB) begin
            o_ab_word <= shreg;                                            // R10
         end else if (tmr_expire) begin
            o_ab_word[POS_FAST_REQ] <= 1'b0;                               // R11
         end
      end
   end

   // fastlock timeout counter, held at load outside mode two
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         tmr <= TIMER_RESET;
      end else if (i_ce) begin
         if (!mode2_run || (load_rise && sel == SEL_AB) || tmr_expire) begin
            tmr <= TIMER_RESET;                                            // R12 R7
         end else if (i_pd_tick) begin
            tmr <= tmr + 7'h01;
         end
      end
   end

   // first-AB-after-init tracker
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ab_first <= 1'b0;
      end else if (i_ce && load_rise) begin
         if (sel == SEL_INIT) begin
            ab_first <= 1'b1;                                              // R17
         end else if (sel == SEL_AB) begin
            ab_first <= 1'b0;                                              // R17
         end
      end
   end

   // internal reset pulse on init words and the first AB word after one
   assign next_pulse = load_rise & ((sel == SEL_INIT)
                       | ((sel == SEL_AB) & ab_first));                    // R16 R17

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_internal_reset <= 1'b0;
      end else if (i_ce) begin
         o_internal_reset <= next_pulse;
      end
   end

   // programmed power-down; sync mode waits so the loop sees no frequency jump
   always_comb begin
      next_pstate = pstate;
      case (pstate)
         PS_ON: begin
            if (func.powerdown_arm_bit && !func.powerdown_sync_select) begin
               next_pstate = PS_DOWN;                                      // R5
            end else if (func.powerdown_arm_bit && o_internal_reset) begin
               // an init word brings the arm bit and the pulse together, so catch it here
               next_pstate = PS_DOWN;                                      // R18
            end else if (func.powerdown_arm_bit) begin
               next_pstate = PS_WAIT;                                      // R6
            end
         end
         PS_WAIT: begin
            if (!func.powerdown_arm_bit) begin
               next_pstate = PS_ON;
            end else if (!func.powerdown_sync_select) begin
               next_pstate = PS_DOWN;                                      // R5
            end else if (i_pump_event || o_internal_reset) begin
               next_pstate = PS_DOWN;                                      // R6 R18
            end
         end
         PS_DOWN: begin
            if (!func.powerdown_arm_bit) begin
               next_pstate = PS_ON;                                        // R24
            end
         end
         default: begin
            next_pstate = PS_ON;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pstate <= PS_ON;
      end else if (i_ce) begin
         pstate <= next_pstate;
      end
   end

   // pin power-down overrides everything; one hold signal keeps R and N aligned
   assign next_pd   = ~i_enable_pin | (next_pstate == PS_DOWN);            // R4 R5
   assign next_hold = next_pd | func.counter_reset_bit | next_pulse;       // R2 R3 R16

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_powerdown         <= 1'b1;
         o_counter_load      <= 1'b1;
         o_pump_highz        <= 1'b1;
         o_lock_detect_reset <= 1'b1;
      end else if (i_ce) begin
         o_powerdown         <= next_pd;
         o_counter_load      <= next_hold;                                 // R7 R2
         o_pump_highz        <= next_hold | func.pump_highz_bit;           // R15 R7
         o_lock_detect_reset <= next_pd;                                   // R7
      end
   end

   // current selection; request bit only counts with fastlock enabled
   assign fast_on = func.fastlock_enable_bit & o_ab_word[POS_FAST_REQ];     // R8 R9

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_pump_current_code <= 3'h0;
      end else if (i_ce) begin
         o_pump_current_code <= fast_on ? func.pump_current_secondary
                                        : func.pump_current_primary;        // R13 R10
      end
   end

   // plain field outputs; prescaler range is the host's concern
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_prescaler_select   <= 2'h0;
         o_monitor_mux_select <= 3'h0;
         o_detector_polarity  <= 1'b0;
      end else if (i_ce) begin
         o_prescaler_select   <= func.prescaler_select;                    // R14
         o_monitor_mux_select <= func.monitor_mux_select;
         o_detector_polarity  <= func.detector_polarity_bit;
      end
   end

   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   AST_FUNC_LOAD: assert property ( // R1
      (i_ce && load_rise && sel == SEL_FUNC) |=> (func == plfc_func_t'($past(shreg))))
      else $error("function word not stored");
   AST_INIT_PULSE: assert property ( // R16
      (i_ce && load_rise && sel == SEL_INIT) |=> o_internal_reset ##0 o_counter_load)
      else $error("init word gave no reset pulse");
   AST_AB_NO_PULSE: assert property ( // R17
      (i_ce && load_rise && sel == SEL_AB && !ab_first) |=> !o_internal_reset)
      else $error("late AB word gave a reset pulse");
   AST_PIN_PD: assert property ( // R4
      (i_ce && !i_enable_pin) |=> o_powerdown)
      else $error("enable pin low did not power down");
   AST_ASYNC_PD: assert property ( // R5
      (i_ce && func.powerdown_arm_bit && !func.powerdown_sync_select) |=> o_powerdown)
      else $error("async power-down late");
   AST_SYNC_WAIT: assert property ( // R6
      (i_ce && pstate == PS_WAIT && i_enable_pin && !i_pump_event && !o_internal_reset
       && func.powerdown_arm_bit && func.powerdown_sync_select) |=> !o_powerdown)
      else $error("sync power-down before pump event");
   AST_PD_FORCES: assert property ( // R7
      o_powerdown |-> (o_counter_load && o_pump_highz && o_lock_detect_reset))
      else $error("power-down did not force load state");
   AST_CNT_RST: assert property ( // R2
      (i_ce && func.counter_reset_bit) |=> (o_counter_load && o_pump_highz))
      else $error("counter reset did not hold counters");
   AST_HIGHZ: assert property ( // R15
      (i_ce && func.pump_highz_bit) |=> o_pump_highz)
      else $error("highz bit ignored");
   AST_CUR_SEL: assert property ( // R13
      (i_ce && !func.fastlock_enable_bit) |=> (o_pump_current_code
       == $past(func.pump_current_primary)))
      else $error("secondary current without fastlock");
   AST_TMR_IDLE: assert property ( // R12
      (i_ce && !func.fastlock_mode_bit) |=> (tmr == TIMER_RESET))
      else $error("timer ran outside mode two");
   AST_TMR_CLEAR: assert property ( // R11
      (i_ce && tmr_expire && !load_rise) |=> !o_ab_word[POS_FAST_REQ])
      else $error("timeout did not clear request");

   // serial port and latch transfers
   AST_SHIFT: assert property ( // R22
      (i_ce && sclk_rise) |=> (shreg == {$past(shreg[22:0]), $past(i_sdata)}))
      else $error("serial bit not shifted in");
   AST_SHIFT_HOLD: assert property ( // R22
      (i_ce && !sclk_rise) |=> $stable(shreg))
      else $error("shift register moved without a serial edge");
   AST_R_LOAD: assert property ( // R23
      (i_ce && load_rise && sel == SEL_R) |=> (o_r_word == $past(shreg)))
      else $error("R word not stored");
   AST_AB_LOAD: assert property ( // R23
      (i_ce && load_rise && sel == SEL_AB) |=> (o_ab_word == $past(shreg)))
      else $error("AB word not stored");
   AST_INIT_LOAD: assert property ( // R16
      (i_ce && load_rise && sel == SEL_INIT) |=> (func == plfc_func_t'($past(shreg))))
      else $error("init word did not load the function latch");
   AST_FIRST_AB_PULSE: assert property ( // R17
      (i_ce && load_rise && sel == SEL_AB && ab_first) |=> o_internal_reset)
      else $error("first AB word after init gave no pulse");
   AST_PULSE_ONE: assert property ( // R16
      (i_ce && o_internal_reset) |=> !o_internal_reset)
      else $error("internal reset pulse longer than one cycle");
   AST_FIELDS: assert property ( // R1
      i_ce |=> (o_prescaler_select == $past(func.prescaler_select)
                && o_monitor_mux_select == $past(func.monitor_mux_select)))
      else $error("function fields not passed on");

   // power-down and counter hold
   AST_PIN_FORCES: assert property ( // R7
      (i_ce && !i_enable_pin) |=> (o_counter_load && o_pump_highz && o_lock_detect_reset))
      else $error("pin power-down did not force load state");
   AST_SYNC_EVENT: assert property ( // R6
      (i_ce && pstate == PS_WAIT && i_pump_event && func.powerdown_arm_bit) |=> o_powerdown)
      else $error("pump event did not end the wait");
   AST_INIT_SYNC_PD: assert property ( // R18
      (i_ce && o_internal_reset && func.powerdown_arm_bit && func.powerdown_sync_select)
      |=> o_powerdown)
      else $error("reset pulse did not start sync power-down");
   AST_PD_HOLD: assert property ( // R24
      (i_ce && pstate == PS_DOWN && func.powerdown_arm_bit) |=> o_powerdown)
      else $error("programmed power-down left early");
   AST_CNT_RST_NO_PD: assert property ( // R2
      (i_ce && func.counter_reset_bit && i_enable_pin && !func.powerdown_arm_bit)
      |=> !o_powerdown)
      else $error("counter reset started a power-down");
   AST_CNT_RELEASE: assert property ( // R3
      (i_ce && i_enable_pin && !func.counter_reset_bit && !next_pulse
       && !func.powerdown_arm_bit) |=> !o_counter_load)
      else $error("counters still held after release");
   AST_HIGHZ_RELEASE: assert property ( // R15
      (i_ce && i_enable_pin && !func.pump_highz_bit && !func.counter_reset_bit
       && !next_pulse && !func.powerdown_arm_bit) |=> !o_pump_highz)
      else $error("pump left in high impedance");

   // fastlock timer and current
   AST_TMR_FREEZE: assert property ( // R12
      (i_ce && mode2_run && !i_pd_tick && !load_rise) |=> $stable(tmr))
      else $error("timer moved without a detector tick");
   AST_TMR_COUNT: assert property ( // R11
      (i_ce && mode2_run && i_pd_tick && !load_rise && !tmr_expire)
      |=> (tmr == 7'($past(tmr) + 7'h01)))
      else $error("timer missed a detector tick");
   AST_SECONDARY: assert property ( // R10
      (i_ce && func.fastlock_enable_bit && o_ab_word[POS_FAST_REQ])
      |=> (o_pump_current_code == $past(func.pump_current_secondary)))
      else $error("secondary current not selected");

   COV_INIT: cover property (i_ce && load_rise && sel == SEL_INIT);
   COV_INIT_SYNC_PD: cover property (o_internal_reset && pstate == PS_ON ##1 o_powerdown);
   COV_SYNC_PD: cover property (pstate == PS_WAIT ##1 pstate == PS_DOWN);
   COV_TIMEOUT: cover property (tmr_expire);
   COV_PIN_PD: cover property (!i_enable_pin ##1 i_enable_pin);

endmodule : plfc_core

// >>> include/plfc_pkg.sv
// constants, field layout and rule summary for the pll function/init latch control
// Function
// [R1] word with select 10 is stored into the function latch
// [R2] counter reset bit high holds R/AB counters at load and three-states pump
// [R3] releasing counter reset restarts N and R counters together
// [R4] enable pin low powers the device down at once
// [R5] arm bit set with sync select 0 powers down immediately
// [R6] arm bit set with sync select 1 waits for next pump event
// [R7] any power-down loads counters, three-states pump, resets lock detect
// [R8] fastlock acts only while fastlock enable bit is 1
// [R9] fastlock mode bit picks mode one (0) or mode two (1)
// [R10] mode one: fast current request selects secondary pump current
// [R11] mode two: timeout clears fast current request, primary current returns
// [R12] timeout counter runs only in fastlock mode two
// [R13] primary current code bits 17:15, secondary bits 20:18
// [R14] host keeps prescaler output at or below 300 MHz
// [R15] pump highz bit three-states the pump output
// [R16] init word loads function latch and issues internal reset pulse
// [R17] first AB load after init repeats pulse, later loads do not
// [R18] init word with sync power-down starts it via the pulse
// [R19] host init order: init, function, R, AB
// [R20] host enable pin method: pin low, write words, pin high
// [R21] host counter reset method: function(1), R, AB, function(0)
// [R22] 24-bit word shifts in MSB first, load strobe edge transfers it
// [R23] low two bits select R, AB, function or init latch
// [R24] programmed power-down persists until arm bit is written 0
package plfc_pkg;
   localparam int WORD_BITS = 24;
   // destination select codes in the low two word bits
   localparam logic [1:0] SEL_R    = 2'h0;
   localparam logic [1:0] SEL_AB   = 2'h1;
   localparam logic [1:0] SEL_FUNC = 2'h2;
   localparam logic [1:0] SEL_INIT = 2'h3;
   // fast current request position in the AB word
   localparam int POS_FAST_REQ = 21;
   // reset values of the latches
   localparam logic [23:0] WORD_RESET = 24'h00_0000;
   // timeout length: (field + 1) detector cycles times this step
   localparam logic [6:0]  TIMEOUT_STEP_TICKS = 7'h04;
   localparam logic [6:0]  TIMER_RESET = 7'h00;

   // function / initialization latch layout, bit 23 first
   typedef struct packed {
      logic [1:0] prescaler_select;
      logic       powerdown_sync_select;
      logic [2:0] pump_current_secondary;
      logic [2:0] pump_current_primary;
      logic [3:0] fastlock_timeout_field;
      logic       fastlock_mode_bit;
      logic       fastlock_enable_bit;
      logic       pump_highz_bit;
      logic       detector_polarity_bit;
      logic [2:0] monitor_mux_select;
      logic       powerdown_arm_bit;
      logic       counter_reset_bit;
      logic       latch_select_high;
      logic       latch_select_low;
   } plfc_func_t;

   // programmed power-down states
   typedef enum logic [2:0] {
      PS_ON   = 3'b001,
      PS_WAIT = 3'b010,
      PS_DOWN = 3'b100
   } plfc_pstate_t;
endpackage : plfc_pkg

// >>> tb/plfc_host.sv
// host model that shifts 24-bit words into the serial load port
`timescale 1ns/1ns
module plfc_host (
   input  wire logic i_clk,          // system clock
   output logic      o_sclk,         // serial clock, idle low between words
   output logic      o_sdata,        // serial data, msb first
   output logic      o_load_strobe   // load strobe, rising edge transfers
);
   initial begin
      o_sclk        = 1'b0;
      o_sdata       = 1'b0;
      o_load_strobe = 1'b0;
   end

   // each serial level stands at least two cycles so the sampled edge detector sees it
   task automatic write_word(input logic [23:0] w);
      for (int b = 23; b >= 0; b--) begin
         @(posedge i_clk);
         o_sdata <= w[b];
         repeat (2) @(posedge i_clk);
         o_sclk <= 1'b1;
         repeat (2) @(posedge i_clk);
         o_sclk <= 1'b0;
      end
      @(posedge i_clk);
      // released data line shows the inverse so a stale bit cannot pass as valid
      o_sdata       <= ~w[0];
      o_load_strobe <= 1'b1;
      repeat (2) @(posedge i_clk);
      o_load_strobe <= 1'b0;
      @(posedge i_clk);
   endtask : write_word
endmodule : plfc_host

// >>> tb/tb_top.sv
// self-checking bench for the function and initialization latch control
`timescale 1ns/1ns
module tb_top;
   import plfc_pkg::*;
   logic        i_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_enable_pin = 1'b1;
   logic        i_pump_event = 1'b0, i_pd_tick = 1'b0;
   logic        sclk, sdata, strobe;
   logic        o_powerdown, o_counter_load, o_pump_highz, o_lock_detect_reset;
   logic        o_internal_reset, o_detector_polarity;
   logic [2:0]  o_pump_current_code, o_monitor_mux_select;
   logic [1:0]  o_prescaler_select;
   logic [23:0] o_r_word, o_ab_word;
   plfc_func_t  f;
   int          error_cnt = 0, n_compared = 0, pulse_cnt = 0;

   plfc_host i_plfc_host (.i_clk(i_clk), .o_sclk(sclk), .o_sdata(sdata), .o_load_strobe(strobe));

   plfc_core i_plfc_core (
      .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_sclk(sclk), .i_sdata(sdata),
      .i_load_strobe(strobe), .i_enable_pin(i_enable_pin), .i_pump_event(i_pump_event),
      .i_pd_tick(i_pd_tick), .o_powerdown(o_powerdown), .o_counter_load(o_counter_load),
      .o_pump_highz(o_pump_highz), .o_lock_detect_reset(o_lock_detect_reset),
      .o_internal_reset(o_internal_reset), .o_pump_current_code(o_pump_current_code),
      .o_prescaler_select(o_prescaler_select), .o_monitor_mux_select(o_monitor_mux_select),
      .o_detector_polarity(o_detector_polarity), .o_r_word(o_r_word), .o_ab_word(o_ab_word)
   );

   initial begin
      forever #10 i_clk = ~i_clk;
   end

   // counts one-cycle internal reset pulses so a missing or extra pulse shows
   always @(posedge i_clk) begin
      if (o_internal_reset === 1'b1) pulse_cnt <= pulse_cnt + 1;
   end

   task automatic end_of_test;
      if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // look just after the edge so registered outputs have settled
   task automatic wt(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : wt

   task automatic wr(input logic [23:0] w);
      i_plfc_host.write_word(w);
      wt(3);
   endtask : wr

   task automatic wr_f(input logic [1:0] sel);
      f.latch_select_high = sel[1];
      f.latch_select_low  = sel[0];
      wr(f);
   endtask : wr_f

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge i_clk) i_pd_tick <= 1'b1;
         @(posedge i_clk) i_pd_tick <= 1'b0;
      end
   endtask : tick

   initial begin
      f = '0;
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b0;
      wt(3);
      chk(o_powerdown, 24'h0);
      chk(o_pump_highz, 24'h0);
      // a low clock enable freezes every flop, so the pin drop waits for it
      @(posedge i_clk) begin
         i_ce         <= 1'b0;
         i_enable_pin <= 1'b0;
      end
      wt(3);
      chk(o_powerdown, 24'h0);
      @(posedge i_clk) i_ce <= 1'b1;
      // pin method: pin low powers down at once, the input register keeps loading
      @(posedge i_clk) i_enable_pin <= 1'b0;
      wt(2);
      chk({o_powerdown, o_counter_load, o_pump_highz, o_lock_detect_reset}, 24'hf);
      wr(24'h12_3454);
      chk(o_r_word, 24'h12_3454);
      @(posedge i_clk) i_enable_pin <= 1'b1;
      wt(2);
      chk(o_powerdown, 24'h0);
      // initialization method with the pulse on the first later AB load only
      wr_f(SEL_INIT);
      chk(pulse_cnt[23:0], 24'h1);
      wr_f(SEL_FUNC);
      wr(24'h00_1230);
      wr(24'h00_1235);
      chk(pulse_cnt[23:0], 24'h2);
      chk(o_ab_word, 24'h00_1235);
      wr(24'h00_1235);
      chk(pulse_cnt[23:0], 24'h2);
      f.pump_highz_bit = 1'b1;
      wr_f(SEL_FUNC);
      chk({o_pump_highz, o_powerdown}, 24'h2);
      // counter reset method: hold counters, no power-down, then release
      f = '0;
      f.counter_reset_bit = 1'b1;
      wr_f(SEL_FUNC);
      chk({o_counter_load, o_pump_highz, o_powerdown}, 24'h6);
      wr(24'h00_1230);
      wr(24'h00_1235);
      f.counter_reset_bit = 1'b0;
      wr_f(SEL_FUNC);
      chk({o_counter_load, o_pump_highz}, 24'h0);
      // asynchronous programmed power-down persists until the arm bit clears
      f.powerdown_arm_bit = 1'b1;
      wr_f(SEL_FUNC);
      chk({o_powerdown, o_lock_detect_reset, o_counter_load}, 24'h7);
      wt(20);
      chk(o_powerdown, 24'h1);
      f = '0;
      wr_f(SEL_FUNC);
      chk(o_powerdown, 24'h0);
      // synchronous power-down waits for a pump event
      f.powerdown_arm_bit     = 1'b1;
      f.powerdown_sync_select = 1'b1;
      wr_f(SEL_FUNC);
      wt(10);
      chk(o_powerdown, 24'h0);
      @(posedge i_clk) i_pump_event <= 1'b1;
      @(posedge i_clk) i_pump_event <= 1'b0;
      wt(2);
      chk({o_powerdown, o_pump_highz}, 24'h3);
      // fastlock mode two with timeout field 1, eight detector ticks
      f = '0;
      f.prescaler_select       = 2'h1;
      f.monitor_mux_select     = 3'h5;
      f.detector_polarity_bit  = 1'b1;
      f.pump_current_primary   = 3'h3;
      f.pump_current_secondary = 3'h5;
      f.fastlock_enable_bit    = 1'b1;
      f.fastlock_mode_bit      = 1'b1;
      f.fastlock_timeout_field = 4'h1;
      wr_f(SEL_FUNC);
      chk({o_powerdown, o_prescaler_select, o_monitor_mux_select}, 24'h0d);
      chk(o_detector_polarity, 24'h1);
      chk(o_pump_current_code, 24'h3);
      wr(24'h20_1235);
      chk(o_pump_current_code, 24'h5);
      tick(7);
      wt(2);
      chk(o_ab_word[POS_FAST_REQ], 24'h1);
      tick(1);
      wt(2);
      chk({o_ab_word[POS_FAST_REQ], o_pump_current_code}, 24'h3);
      // mode one: timer stays idle, only a host write ends fastlock
      f.fastlock_mode_bit = 1'b0;
      wr_f(SEL_FUNC);
      wr(24'h20_1235);
      tick(8);
      wt(2);
      chk(o_pump_current_code, 24'h5);
      wr(24'h00_1235);
      chk(o_pump_current_code, 24'h3);
      f.fastlock_enable_bit = 1'b0;
      wr_f(SEL_FUNC);
      wr(24'h20_1235);
      chk(o_pump_current_code, 24'h3);
      // initialization word programming synchronous power-down
      f = '0;
      f.powerdown_arm_bit     = 1'b1;
      f.powerdown_sync_select = 1'b1;
      wr_f(SEL_INIT);
      chk(o_powerdown, 24'h1);
      end_of_test();
   end

   // a run of about 2900 cycles is expected, so this leaves ample margin
   initial begin
      repeat (20000) @(posedge i_clk);
      error_cnt++;
      end_of_test();
   end
endmodule : tb_top
